// *** logic/aae_pkg.sv ***
`default_nettype none
package aae_pkg;
    // ------------------------------------------------------------
    // opcodes and decode fields
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_ADJ_ADD = 8'h37;
    localparam logic [7:0] OPC_ADJ_SUB = 8'h3f;
    localparam logic [7:0] OPC_ADJ_MUL = 8'hd4;
    localparam logic [7:0] OPC_ADJ_DIV = 8'hd5;
    localparam logic [7:0] ASCII_BASE = 8'h0a;
    localparam logic [3:0] HI_ADD = 4'h0;
    localparam logic [3:0] HI_ADC = 4'h1;
    localparam logic [3:0] HI_IMM = 4'h8;
    localparam logic [2:0] EXT_ADD = 3'b000;
    localparam logic [2:0] EXT_ADC = 3'b010;
    localparam logic [1:0] MOD_REG = 2'b11;
    // ------------------------------------------------------------
    // clocks per instruction on a register or cache hit
    // ------------------------------------------------------------
    localparam logic [4:0] CLK_ADJ_ADDSUB = 5'd3;
    localparam logic [4:0] CLK_ADJ_DIV = 5'd7;
    localparam logic [4:0] CLK_ADJ_MUL = 5'd19;
    localparam logic [4:0] CLK_ADD = 5'd1;
    // ------------------------------------------------------------
    // flag vector layout
    // ------------------------------------------------------------
    localparam int FL_CF = 0;
    localparam int FL_PF = 1;
    localparam int FL_AF = 2;
    localparam int FL_ZF = 3;
    localparam int FL_SF = 4;
    localparam int FL_TF = 5;
    localparam int FL_IF = 6;
    localparam int FL_DF = 7;
    localparam int FL_OF = 8;
    localparam logic [8:0] FLAGS_RST = 9'h000;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_FLAGS = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_PROT = 0;
    localparam int CTRL_OP32 = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int STAT_BUSY = 16;

    typedef enum logic [2:0] {
        AAE_OP_ADD = 3'h0,
        AAE_OP_ADC = 3'h1,
        AAE_OP_AJA = 3'h2,
        AAE_OP_AJS = 3'h3,
        AAE_OP_AJD = 3'h4,
        AAE_OP_AJM = 3'h5
    } aae_op_e;

    // operand mask for byte / 16 / 32 bit width
    function automatic logic [31:0] aae_wmask(input logic w, input logic op32);
        if (!w) begin
            return 32'h0000_00ff;
        end
        return op32 ? 32'hffff_ffff : 32'h0000_ffff;
    endfunction : aae_wmask
endpackage : aae_pkg
`default_nettype wire

// *** logic/aae_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
module aae_alu (
    // operation
    input wire aae_pkg::aae_op_e op_i,
    input wire logic w_i,
    input wire logic op32_i,
    // operands and incoming flags
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    input wire logic [8:0] flags_i,
    // result
    output logic [31:0] res_o,
    output logic [8:0] flags_o,
    output logic [8:0] upd_o
);
    logic [31:0] mask;
    logic [31:0] msb;
    logic [32:0] sum;
    logic cin;
    logic adj;
    logic [7:0] al;
    logic [7:0] ah;
    logic [7:0] tmp;
    logic sa;
    logic sb;
    logic sr;

    always_comb begin
        mask = aae_pkg::aae_wmask(w_i, op32_i); // RULE_13
        msb = mask ^ (mask >> 1);
        cin = (op_i == aae_pkg::AAE_OP_ADC) & flags_i[aae_pkg::FL_CF]; // RULE_14
        sum = {1'b0, a_i & mask} + {1'b0, b_i & mask} + {32'h0000_0000, cin};
        al = a_i[7:0];
        ah = a_i[15:8];
        adj = (al[3:0] > 4'h9) | flags_i[aae_pkg::FL_AF];
        tmp = 8'h00;
        res_o = sum[31:0] & mask; // RULE_14
        flags_o = 9'h000;
        upd_o = 9'h000;
        sa = |(a_i & msb);
        sb = |(b_i & msb);
        sr = |(res_o & msb);
        case (op_i)
            aae_pkg::AAE_OP_ADD, aae_pkg::AAE_OP_ADC: begin
                flags_o[aae_pkg::FL_CF] = sum[32] | (|(sum[31:0] & ~mask));
                flags_o[aae_pkg::FL_AF] = a_i[4] ^ b_i[4] ^ sum[4];
                flags_o[aae_pkg::FL_OF] = (sa == sb) & (sr != sa);
                flags_o[aae_pkg::FL_SF] = sr;
                flags_o[aae_pkg::FL_ZF] = ~|res_o;
                flags_o[aae_pkg::FL_PF] = ~^res_o[7:0];
                upd_o = 9'h11f; // RULE_05 RULE_08
            end
            aae_pkg::AAE_OP_AJA, aae_pkg::AAE_OP_AJS: begin
                if (op_i == aae_pkg::AAE_OP_AJA) begin
                    tmp = al + (adj ? 8'h06 : 8'h00);
                    res_o = {a_i[31:16], ah + {7'h00, adj}, 4'h0, tmp[3:0]};
                end else begin
                    tmp = al - (adj ? 8'h06 : 8'h00);
                    res_o = {a_i[31:16], ah - {7'h00, adj}, 4'h0, tmp[3:0]};
                end
                flags_o[aae_pkg::FL_AF] = adj;
                flags_o[aae_pkg::FL_CF] = adj;
                upd_o = 9'h005; // RULE_01 RULE_04
            end
            aae_pkg::AAE_OP_AJD: begin
                tmp = 8'((16'(ah) * 16'(aae_pkg::ASCII_BASE)) + 16'(al));
                res_o = {a_i[31:16], 8'h00, tmp};
                upd_o = 9'h01a; // RULE_02
            end
            aae_pkg::AAE_OP_AJM: begin
                tmp = al % aae_pkg::ASCII_BASE;
                res_o = {a_i[31:16], al / aae_pkg::ASCII_BASE, tmp};
                upd_o = 9'h01a; // RULE_03
            end
            default: begin
                upd_o = 9'h000;
            end
        endcase
        if (op_i == aae_pkg::AAE_OP_AJD || op_i == aae_pkg::AAE_OP_AJM) begin
            flags_o[aae_pkg::FL_SF] = tmp[7];
            flags_o[aae_pkg::FL_ZF] = ~|tmp;
            flags_o[aae_pkg::FL_PF] = ~^tmp;
        end
    end
endmodule : aae_alu
`default_nettype wire

// *** logic/aae_core.sv ***
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE_01: opcode 37 adjusts AL after add, sets aux carry and carry, 3 clocks.
// RULE_02: D5 0A adjusts AX before divide, sets sign, zero, parity, 7 clocks.
// RULE_03: D4 0A adjusts AX after multiply, sets sign, zero, parity, 19 clocks.
// RULE_04: opcode 3F adjusts AL after subtract, sets aux carry and carry, 3 clocks.
// RULE_05: add-with-carry register form 1[00dw] with mod 11 sets six flags, 1 clock.
// RULE_06: add-with-carry 1[000w] and 1[001w] with ModRM finish in 1 clock.
// RULE_07: add-with-carry immediate is 8[00sw] reg 010, or accumulator 1[010w], 1 clock.
// RULE_08: integer add register form 0[00dw] with mod 11 sets six flags, 1 clock.
// RULE_09: integer add 0[000w] and 0[001w] with ModRM finish in 1 clock.
// RULE_10: integer add immediate is 8[00sw] with reg field 000, 1 clock.
// RULE_11: direction, interrupt enable and trap flags never change here. The code still loads them on a write to REG_FLAGS.
// RULE_12: immediate is 8, 16 or 32 bits; exactly that many bytes are consumed.
// RULE_13: w picks byte or full width, d picks destination, s sign-extends.
// RULE_14: add-with-carry adds incoming carry, plain add ignores it; result to destination.
module aae_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // instruction byte stream
    input wire logic ibyte_valid_i,
    input wire logic [7:0] ibyte_i,
    output logic ibyte_ready_o,
    // decoded instruction towards operand logic
    output logic busy_o,
    output aae_pkg::aae_op_e op_o,
    output logic w_o,
    output logic d_o,
    output logic acc_o,
    output logic imm_form_o,
    output logic [7:0] modrm_o,
    output logic [31:0] imm_o,
    // operands, held stable while busy_o
    input wire logic [31:0] dst_i,
    input wire logic [31:0] src_i,
    // completion
    output logic done_o,
    output logic illegal_o,
    output logic [31:0] result_o,
    output logic [8:0] flags_o
);
    // ------------------------------------------------------------
    // decode state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        AAE_ST_IDLE = 3'b000,
        AAE_ST_SECOND = 3'b001,
        AAE_ST_MODRM = 3'b011,
        AAE_ST_IMM = 3'b010,
        AAE_ST_EXEC = 3'b110
    } aae_st_e;

    aae_st_e state_ff, nxt_state;
    aae_pkg::aae_op_e op_ff, nxt_op;
    logic w_ff, nxt_w;
    logic d_ff, nxt_d;
    logic s_ff, nxt_s;
    logic acc_ff, nxt_acc;
    logic immf_ff, nxt_immf;
    logic [7:0] modrm_ff, nxt_modrm;
    logic [31:0] imm_ff, nxt_imm;
    logic [1:0] idx_ff, nxt_idx;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [31:0] result_ff, nxt_result;
    logic [8:0] flags_ff, nxt_flags;
    logic done_ff, nxt_done;
    logic illegal_ff, nxt_illegal;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;

    logic take;
    logic [31:0] alu_b;
    logic [31:0] alu_res;
    logic [8:0] alu_fl;
    logic [8:0] alu_upd;
    logic wr_en;

    // index of the last immediate byte: immediate length in bytes minus one
    function automatic logic [1:0] imm_last(input logic w, input logic s, input logic op32);
        if (!w || s) begin
            return 2'd0;
        end
        return op32 ? 2'd3 : 2'd1;
    endfunction : imm_last

    // ------------------------------------------------------------
    // execution datapath
    // ------------------------------------------------------------
    always_comb begin
        alu_b = src_i;
        if (immf_ff) begin
            // 8-bit immediate with s set widens by sign
            alu_b = (s_ff && w_ff) ? {{24{imm_ff[7]}}, imm_ff[7:0]} : imm_ff; // RULE_13
        end
    end

    aae_alu u_alu (
        .op_i(op_ff),
        .w_i(w_ff),
        .op32_i(ctrl_ff[aae_pkg::CTRL_OP32]),
        .a_i(dst_i),
        .b_i(alu_b),
        .flags_i(flags_ff),
        .res_o(alu_res),
        .flags_o(alu_fl),
        .upd_o(alu_upd)
    );

    // ------------------------------------------------------------
    // decoder and sequencer
    // ------------------------------------------------------------
    assign take = ibyte_valid_i & ibyte_ready_o;
    assign wr_en = avs_write_i & ack_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_w = w_ff;
        nxt_d = d_ff;
        nxt_s = s_ff;
        nxt_acc = acc_ff;
        nxt_immf = immf_ff;
        nxt_modrm = modrm_ff;
        nxt_imm = imm_ff;
        nxt_idx = idx_ff;
        nxt_cnt = cnt_ff;
        nxt_result = result_ff;
        nxt_flags = flags_ff;
        nxt_done = 1'b0;
        nxt_illegal = 1'b0;
        if (wr_en && avs_address_i == aae_pkg::REG_FLAGS) begin
            nxt_flags = avs_writedata_i[8:0];
        end
        case (state_ff)
            AAE_ST_IDLE: begin
                if (take) begin
                    nxt_w = 1'b1;
                    nxt_d = 1'b0;
                    nxt_s = 1'b0;
                    nxt_acc = 1'b0;
                    nxt_immf = 1'b0;
                    nxt_modrm = 8'h00;
                    nxt_imm = 32'h0000_0000;
                    nxt_idx = 2'd0;
                    nxt_cnt = aae_pkg::CLK_ADD - 5'd1;
                    case (ibyte_i)
                        aae_pkg::OPC_ADJ_ADD, aae_pkg::OPC_ADJ_SUB: begin
                            nxt_op = (ibyte_i == aae_pkg::OPC_ADJ_ADD) ?
                                aae_pkg::AAE_OP_AJA : aae_pkg::AAE_OP_AJS;
                            nxt_cnt = aae_pkg::CLK_ADJ_ADDSUB - 5'd1; // RULE_01 RULE_04
                            nxt_state = AAE_ST_EXEC;
                        end
                        aae_pkg::OPC_ADJ_MUL, aae_pkg::OPC_ADJ_DIV: begin
                            nxt_op = (ibyte_i == aae_pkg::OPC_ADJ_MUL) ?
                                aae_pkg::AAE_OP_AJM : aae_pkg::AAE_OP_AJD;
                            nxt_state = AAE_ST_SECOND;
                        end
                        default: begin
                            nxt_op = (ibyte_i[7:4] == aae_pkg::HI_ADC) ?
                                aae_pkg::AAE_OP_ADC : aae_pkg::AAE_OP_ADD;
                            nxt_w = ibyte_i[0]; // RULE_13
                            nxt_d = ibyte_i[1]; // RULE_13
                            if ((ibyte_i[7:4] == aae_pkg::HI_ADD ||
                                 ibyte_i[7:4] == aae_pkg::HI_ADC) && ibyte_i[3:2] == 2'b00) begin
                                nxt_state = AAE_ST_MODRM; // RULE_05 RULE_06 RULE_08 RULE_09
                            end else if ((ibyte_i[7:4] == aae_pkg::HI_ADD ||
                                          ibyte_i[7:4] == aae_pkg::HI_ADC) &&
                                         ibyte_i[3:1] == 3'b010) begin
                                // accumulator is always the destination
                                nxt_d = 1'b1;
                                nxt_acc = 1'b1;
                                nxt_immf = 1'b1; // RULE_07
                                nxt_state = AAE_ST_IMM;
                            end else if (ibyte_i[7:4] == aae_pkg::HI_IMM &&
                                         ibyte_i[3:2] == 2'b00) begin
                                nxt_d = 1'b0;
                                nxt_s = ibyte_i[1]; // RULE_13
                                nxt_immf = 1'b1;
                                nxt_state = AAE_ST_MODRM;
                            end else begin
                                nxt_illegal = 1'b1;
                            end
                        end
                    endcase
                end
            end
            AAE_ST_SECOND: begin
                if (take) begin
                    if (ibyte_i == aae_pkg::ASCII_BASE) begin
                        nxt_cnt = (op_ff == aae_pkg::AAE_OP_AJM) ?
                            aae_pkg::CLK_ADJ_MUL - 5'd1 : aae_pkg::CLK_ADJ_DIV - 5'd1; // RULE_02 RULE_03
                        nxt_state = AAE_ST_EXEC;
                    end else begin
                        nxt_illegal = 1'b1;
                        nxt_state = AAE_ST_IDLE;
                    end
                end
            end
            AAE_ST_MODRM: begin
                if (take) begin
                    nxt_modrm = ibyte_i;
                    nxt_state = AAE_ST_EXEC;
                    if (immf_ff) begin
                        nxt_state = AAE_ST_IMM;
                        if (ibyte_i[5:3] == aae_pkg::EXT_ADC) begin
                            nxt_op = aae_pkg::AAE_OP_ADC; // RULE_07
                        end else if (ibyte_i[5:3] == aae_pkg::EXT_ADD) begin
                            nxt_op = aae_pkg::AAE_OP_ADD; // RULE_10
                        end else begin
                            nxt_illegal = 1'b1;
                            nxt_state = AAE_ST_IDLE;
                        end
                    end
                end
            end
            AAE_ST_IMM: begin
                if (take) begin
                    nxt_imm = imm_ff | ({24'h00_0000, ibyte_i} << {idx_ff, 3'b000});
                    nxt_idx = idx_ff + 2'd1;
                    if (idx_ff == imm_last(w_ff, s_ff, ctrl_ff[aae_pkg::CTRL_OP32])) begin
                        nxt_state = AAE_ST_EXEC; // RULE_12
                    end
                end
            end
            AAE_ST_EXEC: begin
                if (cnt_ff == 5'd0) begin
                    nxt_result = alu_res; // RULE_14
                    // execution update wins over a register write in the same cycle
                    // untouched bits keep a same-cycle register write
                    nxt_flags = (nxt_flags & ~alu_upd) | (alu_fl & alu_upd); // RULE_11
                    nxt_done = 1'b1;
                    nxt_state = AAE_ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 5'd1;
                end
            end
            default: begin
                nxt_state = AAE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= AAE_ST_IDLE;
            op_ff <= aae_pkg::AAE_OP_ADD;
            w_ff <= 1'b0;
            d_ff <= 1'b0;
            s_ff <= 1'b0;
            acc_ff <= 1'b0;
            immf_ff <= 1'b0;
            modrm_ff <= 8'h00;
            imm_ff <= 32'h0000_0000;
            idx_ff <= 2'd0;
            cnt_ff <= 5'h00;
            result_ff <= 32'h0000_0000;
            flags_ff <= aae_pkg::FLAGS_RST;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            w_ff <= nxt_w;
            d_ff <= nxt_d;
            s_ff <= nxt_s;
            acc_ff <= nxt_acc;
            immf_ff <= nxt_immf;
            modrm_ff <= nxt_modrm;
            imm_ff <= nxt_imm;
            idx_ff <= nxt_idx;
            cnt_ff <= nxt_cnt;
            result_ff <= nxt_result;
            flags_ff <= nxt_flags;
            done_ff <= nxt_done;
            illegal_ff <= nxt_illegal;
        end
    end

    // ------------------------------------------------------------
    // register slave: one wait cycle, answer registered
    // ------------------------------------------------------------
    always_comb begin
        nxt_ack = (avs_read_i | avs_write_i) & ~ack_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rdata = rdata_ff;
        if (wr_en && avs_address_i == aae_pkg::REG_CTRL) begin
            nxt_ctrl = avs_writedata_i[1:0];
        end
        if (avs_read_i && !ack_ff) begin
            case (avs_address_i)
                aae_pkg::REG_CTRL: nxt_rdata = {30'h0000_0000, ctrl_ff};
                aae_pkg::REG_FLAGS: nxt_rdata = {23'h00_0000, flags_ff};
                aae_pkg::REG_STATUS: nxt_rdata = {15'h0000, busy_o, 7'h00, flags_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_ff <= aae_pkg::CTRL_RST;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
    assign avs_readdata_o = rdata_ff;
    assign ibyte_ready_o = (state_ff != AAE_ST_EXEC);
    assign busy_o = (state_ff == AAE_ST_EXEC);
    assign op_o = op_ff;
    assign w_o = w_ff;
    assign d_o = d_ff;
    assign acc_o = acc_ff;
    assign imm_form_o = immf_ff;
    assign modrm_o = modrm_ff;
    assign imm_o = imm_ff;
    assign done_o = done_ff;
    assign illegal_o = illegal_ff;
    assign result_o = result_ff;
    assign flags_o = flags_ff;
endmodule : aae_core
`default_nettype wire

// *** tb/aae_opnd_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module aae_opnd_model (
    // execute window
    input wire logic busy_i,
    input wire logic [31:0] dst_val_i,
    input wire logic [31:0] src_val_i,
    // operands towards the core
    output logic [31:0] dst_o,
    output logic [31:0] src_o
);
    // ----
    // operand drive
    // ----
    // outside execution the operands are released: the inverse makes a late sample wrong
    always_comb begin
        dst_o = busy_i ? dst_val_i : ~dst_val_i;
        src_o = busy_i ? src_val_i : ~src_val_i;
    end
endmodule : aae_opnd_model
`default_nettype wire

// *** tb/aae_core_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module aae_core_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // watched ports
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic busy_o,
    input wire aae_pkg::aae_op_e op_o,
    input wire logic done_o,
    input wire logic illegal_o,
    input wire logic [8:0] flags_o
);
    // ----
    // length of the busy run that just ended
    // ----
    logic [4:0] run_ff;
    logic [4:0] nxt_run;
    always_comb begin
        nxt_run = busy_o ? run_ff + 5'h1 : 5'h0;
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_ff <= 5'h0;
        end else begin
            run_ff <= nxt_run;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // ----
    // properties
    // ----
    property p_one_wait;
        (avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait too long");
    property p_done_pulse;
        done_o |=> !done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_keep_ctl;
        done_o |-> flags_o[7:5] == $past(flags_o[7:5]);
    endproperty
    a_keep_ctl: assert property (p_keep_ctl) else $error("control flags moved");
    property p_clk_add;
        done_o && op_o inside {aae_pkg::AAE_OP_ADD, aae_pkg::AAE_OP_ADC} |-> run_ff == 5'h1;
    endproperty
    a_clk_add: assert property (p_clk_add) else $error("add clocks");
    property p_clk_adj;
        done_o && op_o inside {aae_pkg::AAE_OP_AJA, aae_pkg::AAE_OP_AJS} |-> run_ff == 5'h3;
    endproperty
    a_clk_adj: assert property (p_clk_adj) else $error("adjust clocks");
    property p_clk_div;
        done_o && op_o == aae_pkg::AAE_OP_AJD |-> run_ff == 5'h7;
    endproperty
    a_clk_div: assert property (p_clk_div) else $error("divide adjust clocks");
    property p_clk_mul;
        done_o && op_o == aae_pkg::AAE_OP_AJM |-> run_ff == 5'h13;
    endproperty
    a_clk_mul: assert property (p_clk_mul) else $error("multiply adjust clocks");
    property p_ill_idle;
        illegal_o |-> !busy_o ##1 !illegal_o;
    endproperty
    a_ill_idle: assert property (p_ill_idle) else $error("refusal not idle");
endmodule : aae_core_assertions
bind aae_core aae_core_assertions u_chk (
    .clk_i, .rst_b_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .busy_o, .op_o,
    .done_o, .illegal_o, .flags_o
);
`default_nettype wire

// *** tb/aae_core_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module aae_core_tb;
    // ----
    // bench signals
    // ----
    logic clk_i, rst_b_i, rd, wr, ivld, irdy, wreq, busy, dbit, acc, done, ill, wbit, immf;
    logic [2:0] opv;
    logic [3:0] adr;
    logic [7:0] ibyt, mrm;
    logic [8:0] flg;
    logic [31:0] wdat, rdat, imm, dst, src, dval, sval, res, rv;
    int bad_count, checks_done, nbusy;
    aae_core DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .ibyte_valid_i(ivld), .ibyte_i(ibyt),
        .ibyte_ready_o(irdy), .busy_o(busy), .op_o(opv), .w_o(wbit), .d_o(dbit), .acc_o(acc),
        .imm_form_o(immf), .modrm_o(mrm), .imm_o(imm), .dst_i(dst), .src_i(src), .done_o(done),
        .illegal_o(ill), .result_o(res), .flags_o(flg)
    );
    aae_opnd_model u_opnd (
        .busy_i(busy), .dst_val_i(dval), .src_val_i(sval), .dst_o(dst), .src_o(src)
    );
    initial begin
        clk_i = 1'b0;
        forever begin
            #5 clk_i = ~clk_i;
        end
    end
    // ----
    // compare and verdict
    // ----
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    // a handshake that never completes counts as a mismatch
    task automatic stall(input int n);
        if (n >= 40) begin
            bad_count++;
            print_verdict();
        end
    endtask : stall
    // ----
    // drivers
    // ----
    task automatic bus(input logic wnr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        adr <= a;
        wr <= wnr;
        rd <= ~wnr;
        wdat <= d;
        n = 0;
        // waitrequest and read data are taken at the rising edge that ends the wait
        do begin
            @(posedge clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        stall(n);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // bytes go lsb first; en of zero means the opcode must be refused
    task automatic t(input logic [47:0] s, input int nb, input logic [31:0] dv, sv, er,
            input logic [8:0] ef, input int en);
        int n;
        @(posedge clk_i);
        dval <= dv;
        sval <= sv;
        for (int i = 0; i < nb; i++) begin
            ivld <= 1'b1;
            ibyt <= s[8*i +: 8];
            @(posedge clk_i);
        end
        ivld <= 1'b0;
        nbusy = 0;
        n = 0;
        do begin
            @(negedge clk_i);
            nbusy += int'(busy === 1'b1);
            n++;
        end while (done !== 1'b1 && ill !== 1'b1 && n < 40);
        stall(n);
        if (en == 0) begin
            chk("refused", {31'h0, ill}, 32'h1);
        end else begin
            chk("result", res, er);
            chk("flags", {23'h0, flg}, {23'h0, ef});
            chk("clocks", 32'(nbusy), 32'(en));
        end
    endtask : t
    // ----
    // sequence
    // ----
    initial begin
        rst_b_i = 1'b0;
        {rd, wr, ivld, adr, ibyt, wdat, dval, sval} = '0;
        bad_count = 0;
        checks_done = 0;
        repeat (2) @(posedge clk_i);
        chk("ready", {31'h0, irdy}, 32'h1);
        rst_b_i <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl", rv, 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        chk("status", rv, 32'h0);
        bus(1'b1, 4'h4, 32'h0e0);
        bus(1'b1, 4'h8, 32'h1ff);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(1'b0, 4'hc, 32'h0);
        chk("unmapped", rv, 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        chk("status", rv, 32'h0e0);
        t(48'hc800, 2, 32'hff, 32'h1, 32'h0, 9'h0ef, 1);
        t(48'hc810, 2, 32'h7f, 32'h0, 32'h80, 9'h1f4, 1);
        t(48'h0612, 2, 32'h1, 32'h1, 32'h2, 9'h0e0, 1);
        chk("d", {31'h0, dbit}, 32'h1);
        chk("w", {31'h0, wbit}, 32'h0);
        chk("modrm", {24'h0, mrm}, 32'h6);
        bus(1'b1, 4'h0, 32'h2);
        t(48'hffd083, 3, 32'h1, 32'h0, 32'h0, 9'h0ef, 1);
        chk("immform", {31'h0, immf}, 32'h1);
        chk("op", {29'h0, opv}, 32'h1);
        t(48'h12345678c081, 6, 32'h0, 32'h0, 32'h12345678, 9'h0e2, 1);
        chk("imm", imm, 32'h12345678);
        bus(1'b1, 4'h0, 32'h0);
        t(48'hffffc081, 4, 32'h1, 32'h0, 32'h0, 9'h0ef, 1);
        t(48'h0514, 2, 32'h10, 32'h0, 32'h16, 9'h0e0, 1);
        chk("acc", {31'h0, acc}, 32'h1);
        t(48'h4801, 2, 32'h7fff, 32'h1, 32'h8000, 9'h1f6, 1);
        bus(1'b1, 4'h4, 32'h0e0);
        t(48'h3f, 1, 32'h5, 32'h0, 32'h5, 9'h0e0, 3);
        t(48'h37, 1, 32'ha, 32'h0, 32'h100, 9'h0e5, 3);
        t(48'h0ad5, 2, 32'h0, 32'h0, 32'h0, 9'h0ef, 7);
        t(48'h0ad4, 2, 32'h7, 32'h0, 32'h7, 9'h0e5, 19);
        t(48'h0bd5, 2, 32'h0, 32'h0, 32'h0, 9'h0, 0);
        t(48'hc880, 2, 32'h0, 32'h0, 32'h0, 9'h0, 0);
        t(48'hf4, 1, 32'h0, 32'h0, 32'h0, 9'h0, 0);
        bus(1'b0, 4'h8, 32'h0);
        chk("status", rv, 32'h0e5);
        print_verdict();
    end
endmodule : aae_core_tb
`default_nettype wire
